/* design/input_sync.sv */
// Three-stage input synchroniser with agreement filter
module input_sync #(
    parameter int WIDTH = 1
) (
    // Clock and reset
    input wire logic clk_sys_i,
    input wire logic reset_n_i,
    // Foreign-domain inputs and settled outputs
    input wire logic [WIDTH-1:0] async_i,
    output logic [WIDTH-1:0] stable_o
);
    logic [WIDTH-1:0] stage1;
    logic [WIDTH-1:0] stage2;
    logic [WIDTH-1:0] stage3;
    wire logic [WIDTH-1:0] agree;

    // Stage one feeds stage two only; metastability never reaches logic
    assign agree = ~(stage2 ^ stage3);

    always_ff @(posedge clk_sys_i) begin
        if (!reset_n_i) begin
            stage1 <= '0;
            stage2 <= '0;
            stage3 <= '0;
            stable_o <= '0;
        end else begin
            stage1 <= async_i;
            stage2 <= stage1;
            stage3 <= stage2;
            stable_o <= (stage2 & agree) | (stable_o & ~agree);
        end
    end
endmodule // input_sync

/* design/pll_power_status_regs.sv */
// PLL power control, calibration word and lock/error flag registers
//
// Function
// - Power control at 5h, 16 bits, resets 30h
// - Bit 10 shuts second VCO buffer regulator
// - Bit 9 turns off VCO regulator
// - Bit 8 shuts down VCO output buffer
// - Bit 7 shuts charge pump regulator
// - Bit 6 disables PLL lock detector
// - Bit 5 powers down prescaler B, resets one
// - Bit 4 prescaler A, low in reset, then one
// - Bit 2 detector off until calibration, then zero
// - Bit 1 main prescaler, low in reset, then one
// - Calibration word at 6h, read-only, resets zero
// - Flags at 7h: reserved, read-only, read-clear, sticky
// - Flag bit 11 shows live PLL lock
// - Bit 1 sticky on lock loss until recalibration/reset
// - Bit 4 shows non-volatile memory busy
// - Bit 9 set on overlapping memory read operation
module pll_power_status_regs
    import pll_regs_pkg::*;
(
    // Clock and reset
    input wire logic clk_sys_i,
    input wire logic reset_n_i,
    // Register access from the serial port engine
    input wire logic [pll_regs_pkg::ADDR_W-1:0] reg_addr_i,
    input wire logic [pll_regs_pkg::DATA_W-1:0] reg_wdata_i,
    input wire logic reg_wr_i,
    input wire logic reg_rd_i,
    output logic [pll_regs_pkg::DATA_W-1:0] reg_rdata_o,
    output logic reg_rvalid_o,
    // Status from the analog and memory domains (asynchronous)
    input wire logic pll_lock_i,
    input wire logic vco_cal_ready_i,
    input wire logic nvm_crc_error_i,
    input wire logic nvm_busy_i,
    input wire logic cal_done_i,
    input wire logic config_done_i,
    input wire logic freq_lock_i,
    input wire logic nvm_read_phase_i,
    input wire logic nvm_write_phase_i,
    input wire logic hard_reset_sync_pin_n_i,
    input wire logic por_done_i,
    input wire logic [pll_regs_pkg::DATA_W-1:0] cal_word_i,
    // Events from logic on this clock
    input wire logic nvm_op_issue_i,
    input wire logic recal_start_i,
    input wire logic serial_rd_error_i,
    input wire logic serial_wr_error_i,
    // Power-down controls to the PLL
    output logic second_vco_buffer_regulator_off_o,
    output logic vco_regulator_off_o,
    output logic vco_buffer_off_o,
    output logic charge_pump_regulator_off_o,
    output logic lock_detector_off_o,
    output logic prescaler_b_off_o,
    output logic prescaler_a_off_o,
    output logic phase_detector_off_o,
    output logic main_prescaler_off_o,
    output logic input_path_regulator_off_o
);
    import pll_regs_pkg::*;

    logic [DATA_W-1:0] power_ctrl;
    logic [DATA_W-1:0] next_power_ctrl;
    logic nvm_rd_error;
    logic nvm_wr_error;
    logic unlock_sticky;
    logic lock_prev;
    logic por_prev;
    logic cal_prev;
    logic [ASYNC_FLAG_W-1:0] flags_sync;
    logic [DATA_W-1:0] cal_word_sync;

    wire logic s_lock;
    wire logic s_vco_ready;
    wire logic s_crc_err;
    wire logic s_busy;
    wire logic s_cal_done;
    wire logic s_config_done;
    wire logic s_freq_lock;
    wire logic s_rd_phase;
    wire logic s_wr_phase;
    wire logic s_pin_n;
    wire logic s_por_done;
    wire logic wr_power;
    wire logic rd_flags;
    wire logic lock_lost;
    wire logic por_rise;
    wire logic cal_rise;
    wire logic set_nvm_rd_error;
    wire logic set_nvm_wr_error;
    wire logic [DATA_W-1:0] flags_word;
    wire logic [DATA_W-1:0] read_mux;

    // Address match used by both the write and read decoders
    function automatic logic hit(input logic [ADDR_W-1:0] addr, input logic [7:0] target);
        return addr == target;
    endfunction

    input_sync #(
        .WIDTH(ASYNC_FLAG_W + DATA_W)
    ) u_sync (
        .clk_sys_i(clk_sys_i),
        .reset_n_i(reset_n_i),
        .async_i({por_done_i, hard_reset_sync_pin_n_i, nvm_write_phase_i, nvm_read_phase_i,
                  freq_lock_i, config_done_i, cal_done_i, nvm_busy_i, nvm_crc_error_i,
                  vco_cal_ready_i, pll_lock_i, cal_word_i}),
        .stable_o({flags_sync, cal_word_sync})
    );

    // Pin comes out low in reset, so hard-reset clear holds until it settles high
    assign {s_por_done, s_pin_n, s_wr_phase, s_rd_phase, s_freq_lock, s_config_done,
            s_cal_done, s_busy, s_crc_err, s_vco_ready, s_lock} = flags_sync;

    assign wr_power = reg_wr_i && hit(reg_addr_i, ADDR_POWER_CTRL);
    assign rd_flags = reg_rd_i && hit(reg_addr_i, ADDR_FLAGS);
    assign lock_lost = lock_prev && !s_lock;
    assign por_rise = s_por_done && !por_prev;
    assign cal_rise = s_cal_done && !cal_prev;
    assign set_nvm_rd_error = nvm_op_issue_i && s_rd_phase;
    assign set_nvm_wr_error = nvm_op_issue_i && s_wr_phase;

    always_comb begin
        next_power_ctrl = power_ctrl;
        if (wr_power) begin
            next_power_ctrl = reg_wdata_i;
        end
        if (por_rise) begin
            next_power_ctrl[PWR_PRESCALER_A_OFF] = 1'b1;
            next_power_ctrl[PWR_MAIN_PRESCALER_OFF] = 1'b1;
        end
        if (cal_rise) begin
            next_power_ctrl[PWR_PFD_OFF] = 1'b0;
        end
    end

    always_ff @(posedge clk_sys_i) begin
        if (!reset_n_i) begin
            power_ctrl <= POWER_CTRL_RESET;
            lock_prev <= 1'b0;
            por_prev <= 1'b0;
            cal_prev <= 1'b0;
        end else begin
            power_ctrl <= next_power_ctrl;
            lock_prev <= s_lock;
            por_prev <= s_por_done;
            cal_prev <= s_cal_done;
        end
    end

    // Hardware set wins over the clearing read in the same cycle
    always_ff @(posedge clk_sys_i) begin
        if (!reset_n_i) begin
            nvm_rd_error <= 1'b0;
            nvm_wr_error <= 1'b0;
        end else begin
            nvm_rd_error <= set_nvm_rd_error || (nvm_rd_error && !rd_flags);
            nvm_wr_error <= set_nvm_wr_error || (nvm_wr_error && !rd_flags);
        end
    end

    always_ff @(posedge clk_sys_i) begin
        if (!reset_n_i) begin
            unlock_sticky <= 1'b0;
        end else begin
            unlock_sticky <= lock_lost || (unlock_sticky && !recal_start_i && s_pin_n);
        end
    end

    assign flags_word = {4'h0,
                         s_lock,
                         s_vco_ready,
                         nvm_rd_error,
                         nvm_wr_error,
                         serial_rd_error_i,
                         serial_wr_error_i,
                         s_crc_err,
                         s_busy,
                         s_cal_done,
                         s_config_done,
                         unlock_sticky,
                         s_freq_lock};

    assign read_mux = hit(reg_addr_i, ADDR_POWER_CTRL) ? power_ctrl :
                      hit(reg_addr_i, ADDR_CAL_WORD) ? cal_word_sync :
                      hit(reg_addr_i, ADDR_FLAGS) ? flags_word : READ_UNMAPPED;

    always_ff @(posedge clk_sys_i) begin
        if (!reset_n_i) begin
            reg_rdata_o <= FLAGS_RESET;
            reg_rvalid_o <= 1'b0;
        end else begin
            reg_rdata_o <= reg_rd_i ? read_mux : reg_rdata_o;
            reg_rvalid_o <= reg_rd_i;
        end
    end

    // Power-down outputs registered so no decode glitch reaches the analog
    always_ff @(posedge clk_sys_i) begin
        if (!reset_n_i) begin
            second_vco_buffer_regulator_off_o <= 1'b0;
            vco_regulator_off_o <= 1'b0;
            vco_buffer_off_o <= 1'b0;
            charge_pump_regulator_off_o <= 1'b0;
            lock_detector_off_o <= 1'b0;
            prescaler_b_off_o <= 1'b1;
            prescaler_a_off_o <= 1'b0;
            phase_detector_off_o <= 1'b1;
            main_prescaler_off_o <= 1'b0;
            input_path_regulator_off_o <= 1'b0;
        end else begin
            second_vco_buffer_regulator_off_o <= power_ctrl[PWR_VCOBUF2_REG_OFF];
            vco_regulator_off_o <= power_ctrl[PWR_VCO_REG_OFF];
            vco_buffer_off_o <= power_ctrl[PWR_VCOBUF_OFF];
            charge_pump_regulator_off_o <= power_ctrl[PWR_CP_REG_OFF];
            lock_detector_off_o <= power_ctrl[PWR_LOCKDET_OFF];
            prescaler_b_off_o <= power_ctrl[PWR_PRESCALER_B_OFF];
            prescaler_a_off_o <= s_por_done && power_ctrl[PWR_PRESCALER_A_OFF];
            phase_detector_off_o <= !s_cal_done || power_ctrl[PWR_PFD_OFF];
            main_prescaler_off_o <= s_por_done && power_ctrl[PWR_MAIN_PRESCALER_OFF];
            // passed through, software keeps it clear
            input_path_regulator_off_o <= power_ctrl[PWR_INPUT_REG_OFF];
        end
    end
endmodule // pll_power_status_regs

/* design/pll_regs_pkg.sv */
// Constants shared by the PLL power and status register slice
package pll_regs_pkg;

    // Register access port geometry
    localparam int DATA_W = 16;
    localparam int ADDR_W = 8;

    // Register addresses
    localparam logic [7:0] ADDR_POWER_CTRL = 8'h05;
    localparam logic [7:0] ADDR_CAL_WORD = 8'h06;
    localparam logic [7:0] ADDR_FLAGS = 8'h07;

    // Values after reset
    localparam logic [15:0] POWER_CTRL_RESET = 16'h0030;
    localparam logic [15:0] CAL_WORD_RESET = 16'h0000;
    localparam logic [15:0] FLAGS_RESET = 16'h0000;
    localparam logic [15:0] READ_UNMAPPED = 16'h0000;

    // Power control bit positions
    localparam int PWR_VCOBUF2_REG_OFF = 10;
    localparam int PWR_VCO_REG_OFF = 9;
    localparam int PWR_VCOBUF_OFF = 8;
    localparam int PWR_CP_REG_OFF = 7;
    localparam int PWR_LOCKDET_OFF = 6;
    localparam int PWR_PRESCALER_B_OFF = 5;
    localparam int PWR_PRESCALER_A_OFF = 4;
    localparam int PWR_PFD_OFF = 2;
    localparam int PWR_MAIN_PRESCALER_OFF = 1;
    localparam int PWR_INPUT_REG_OFF = 0;

    // Status flag bit positions
    localparam int FLG_LOCK_LIVE = 11;
    localparam int FLG_VCO_CAL_READY = 10;
    localparam int FLG_NVM_RD_ERROR = 9;
    localparam int FLG_NVM_WR_ERROR = 8;
    localparam int FLG_RD_ERROR = 7;
    localparam int FLG_WR_ERROR = 6;
    localparam int FLG_NVM_CRC_ERROR = 5;
    localparam int FLG_NVM_BUSY = 4;
    localparam int FLG_CAL_DONE = 3;
    localparam int FLG_CONFIG_DONE = 2;
    localparam int FLG_UNLOCK_STICKY = 1;
    localparam int FLG_FREQ_LOCK = 0;

    // Synchroniser depth and width of the foreign-domain flag vector
    localparam int SYNC_STAGES = 3;
    localparam int ASYNC_FLAG_W = 11;

endpackage : pll_regs_pkg

/* tb/pll_power_status_regs_chk.sv */
// Assertion checker for the PLL power and status register slice
module pll_power_status_regs_chk
    import pll_regs_pkg::*;
(
    // Clock, reset and register port
    input wire logic clk_sys_i,
    input wire logic reset_n_i,
    input wire logic [pll_regs_pkg::ADDR_W-1:0] reg_addr_i,
    input wire logic [pll_regs_pkg::DATA_W-1:0] reg_wdata_i,
    input wire logic reg_wr_i,
    input wire logic reg_rd_i,
    input wire logic [pll_regs_pkg::DATA_W-1:0] reg_rdata_o,
    input wire logic reg_rvalid_o,
    // Status inputs
    input wire logic pll_lock_i,
    input wire logic cal_done_i,
    input wire logic por_done_i,
    input wire logic nvm_op_issue_i,
    input wire logic [pll_regs_pkg::DATA_W-1:0] cal_word_i,
    // Power-down outputs
    input wire logic second_vco_buffer_regulator_off_o,
    input wire logic vco_regulator_off_o,
    input wire logic vco_buffer_off_o,
    input wire logic charge_pump_regulator_off_o,
    input wire logic lock_detector_off_o,
    input wire logic prescaler_a_off_o,
    input wire logic phase_detector_off_o,
    input wire logic main_prescaler_off_o
);
    default clocking @(posedge clk_sys_i); endclocking
    default disable iff (!reset_n_i);
    wire wr_pwr = reg_wr_i && reg_addr_i == ADDR_POWER_CTRL;
    wire rd_flags = reg_rd_i && reg_addr_i == ADDR_FLAGS;
    wire rd_cal = reg_rd_i && reg_addr_i == ADDR_CAL_WORD;
    wire [4:0] upper_off = {second_vco_buffer_regulator_off_o, vco_regulator_off_o,
        vco_buffer_off_o, charge_pump_regulator_off_o, lock_detector_off_o};

    AST_RVALID:
    assert property (reg_rd_i |=> reg_rvalid_o) else $error("read not answered");
    AST_UNMAPPED:
    assert property (reg_rd_i && (reg_addr_i < ADDR_POWER_CTRL || reg_addr_i > ADDR_FLAGS)
        |=> reg_rdata_o == 16'h0000) else $error("unmapped read not zero");
    AST_PWR_BITS:
    assert property (wr_pwr |-> ##2 upper_off == $past(reg_wdata_i[10:6], 2))
        else $error("power output not following write");
    AST_RD_CLEAR:
    assert property (rd_flags && !nvm_op_issue_i ##1 !nvm_op_issue_i ##1 rd_flags
        |=> reg_rdata_o[9:8] == 2'b00) else $error("memory error flags not cleared");
    AST_LOCK_LIVE:
    assert property ($stable(pll_lock_i)[*8] ##0 rd_flags |=> reg_rdata_o[11] == $past(pll_lock_i))
        else $error("lock flag wrong");
    AST_CAL_WORD:
    assert property ($stable(cal_word_i)[*8] ##0 rd_cal |=> reg_rdata_o == $past(cal_word_i))
        else $error("calibration word wrong");
    AST_PRESCALERS_HELD:
    assert property ((!por_done_i)[*8] |-> !prescaler_a_off_o && !main_prescaler_off_o)
        else $error("prescaler off before power-on done");
    AST_PFD_HELD:
    assert property ((!cal_done_i)[*8] |-> phase_detector_off_o)
        else $error("phase detector on before calibration");
endmodule // pll_power_status_regs_chk

bind pll_power_status_regs pll_power_status_regs_chk pll_power_status_regs_chk_inst (.*);

/* tb/pll_power_status_regs_tb.sv */
// Self-checking bench for the PLL power and status register slice
module pll_power_status_regs_tb;
    timeunit 1ns;
    timeprecision 1ps;
    import pll_regs_pkg::*;

    logic clk_sys_i = 1'b0, reset_n_i = 1'b0;
    logic pll_lock_i = 1'b0, vco_cal_ready_i = 1'b0, nvm_crc_error_i = 1'b0, nvm_busy_i = 1'b0;
    logic cal_done_i = 1'b0, config_done_i = 1'b0, freq_lock_i = 1'b0, por_done_i = 1'b0;
    logic nvm_read_phase_i = 1'b0, nvm_write_phase_i = 1'b0, hard_reset_sync_pin_n_i = 1'b1;
    logic nvm_op_issue_i = 1'b0, recal_start_i = 1'b0;
    logic serial_rd_error_i = 1'b0, serial_wr_error_i = 1'b0;
    logic [15:0] cal_word_i = 16'h0000, reg_wdata_i, reg_rdata_o, rd_val;
    logic [7:0] reg_addr_i;
    logic reg_wr_i, reg_rd_i, reg_rvalid_o;
    logic [9:0] pd;
    int bad_count = 0, cmp_count = 0, cycles = 0;

    initial begin
        forever #12.5 clk_sys_i = ~clk_sys_i;
    end

    reg_host_model host_inst (.clk_sys_i(clk_sys_i), .reg_addr_o(reg_addr_i),
        .reg_wdata_o(reg_wdata_i), .reg_wr_o(reg_wr_i), .reg_rd_o(reg_rd_i),
        .reg_rdata_i(reg_rdata_o), .reg_rvalid_i(reg_rvalid_o));

    pll_power_status_regs pll_power_status_regs_inst (
        .second_vco_buffer_regulator_off_o(pd[9]), .vco_regulator_off_o(pd[8]),
        .vco_buffer_off_o(pd[7]), .charge_pump_regulator_off_o(pd[6]),
        .lock_detector_off_o(pd[5]), .prescaler_b_off_o(pd[4]), .prescaler_a_off_o(pd[3]),
        .phase_detector_off_o(pd[2]), .main_prescaler_off_o(pd[1]),
        .input_path_regulator_off_o(pd[0]), .*);

    task automatic check(input logic [15:0] got, input logic [15:0] exp);
        cmp_count++;
        if (got !== exp) begin
            bad_count++;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic rd_check(input logic [7:0] a, input logic [15:0] exp);
        host_inst.host_read(a, rd_val);
        check(rd_val, exp);
    endtask

    // Long enough for every synchroniser to settle
    task automatic settle;
        repeat (8) @(posedge clk_sys_i);
    endtask

    task automatic tally_and_finish;
        $display("comparisons %0d mismatches %0d", cmp_count, bad_count);
        if (bad_count == 0 && cmp_count > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask

    always @(posedge clk_sys_i) begin
        cycles++;
        if (cycles == 3000) begin
            bad_count++;
            tally_and_finish();
        end
    end

    initial begin
        repeat (2) @(posedge clk_sys_i);
        reset_n_i <= 1'b1;
        rd_check(ADDR_POWER_CTRL, 16'h0030);
        check({6'h00, pd}, 16'h0014);
        rd_check(ADDR_FLAGS, 16'h0000);
        rd_check(ADDR_CAL_WORD, 16'h0000);
        // Power-on kept low long enough for the held-low prescaler check to engage
        settle();
        por_done_i <= 1'b1;
        cal_word_i <= 16'hA5C3;
        settle();
        rd_check(ADDR_POWER_CTRL, 16'h0032);
        check({6'h00, pd}, 16'h001E);
        host_inst.host_write(ADDR_POWER_CTRL, 16'h0036);
        rd_check(ADDR_POWER_CTRL, 16'h0036);
        @(posedge clk_sys_i);
        cal_done_i <= 1'b1;
        settle();
        rd_check(ADDR_POWER_CTRL, 16'h0032);
        check({6'h00, pd}, 16'h001A);
        host_inst.host_write(ADDR_POWER_CTRL, 16'hFFFE);
        rd_check(ADDR_POWER_CTRL, 16'hFFFE);
        check({6'h00, pd}, 16'h03FE);
        host_inst.host_write(ADDR_CAL_WORD, 16'h0000);
        host_inst.host_write(ADDR_FLAGS, 16'hFFFE);
        host_inst.host_write(8'h20, 16'h0000);
        rd_check(ADDR_POWER_CTRL, 16'hFFFE);
        rd_check(ADDR_CAL_WORD, 16'hA5C3);
        rd_check(8'h20, 16'h0000);
        host_inst.host_write(ADDR_POWER_CTRL, 16'h0000);
        rd_check(ADDR_POWER_CTRL, 16'h0000);
        check({6'h00, pd}, 16'h0000);
        @(posedge clk_sys_i);
        {pll_lock_i, vco_cal_ready_i, nvm_crc_error_i, nvm_busy_i} <= 4'hF;
        {config_done_i, freq_lock_i, serial_rd_error_i, serial_wr_error_i} <= 4'hF;
        settle();
        rd_check(ADDR_FLAGS, 16'h0CFD);
        @(posedge clk_sys_i);
        {pll_lock_i, nvm_crc_error_i, serial_rd_error_i, serial_wr_error_i} <= 4'h0;
        settle();
        rd_check(ADDR_FLAGS, 16'h041F);
        @(posedge clk_sys_i);
        recal_start_i <= 1'b1;
        @(posedge clk_sys_i);
        recal_start_i <= 1'b0;
        rd_check(ADDR_FLAGS, 16'h041D);
        @(posedge clk_sys_i);
        pll_lock_i <= 1'b1;
        settle();
        {pll_lock_i, hard_reset_sync_pin_n_i} <= 2'b00;
        settle();
        hard_reset_sync_pin_n_i <= 1'b1;
        {nvm_read_phase_i, nvm_write_phase_i} <= 2'b11;
        settle();
        rd_check(ADDR_FLAGS, 16'h041D);
        @(posedge clk_sys_i);
        nvm_op_issue_i <= 1'b1;
        @(posedge clk_sys_i);
        nvm_op_issue_i <= 1'b0;
        rd_check(ADDR_FLAGS, 16'h071D);
        rd_check(ADDR_FLAGS, 16'h041D);
        tally_and_finish();
    end
endmodule // pll_power_status_regs_tb

/* tb/reg_host_model.sv */
// Host side model issuing single-word register reads and writes
module reg_host_model
    import pll_regs_pkg::*;
(
    // Clock
    input wire logic clk_sys_i,
    // Register port towards the slice
    output logic [pll_regs_pkg::ADDR_W-1:0] reg_addr_o,
    output logic [pll_regs_pkg::DATA_W-1:0] reg_wdata_o,
    output logic reg_wr_o,
    output logic reg_rd_o,
    input wire logic [pll_regs_pkg::DATA_W-1:0] reg_rdata_i,
    input wire logic reg_rvalid_i
);
    timeunit 1ns;
    timeprecision 1ps;

    initial begin
        reg_addr_o = 8'h00;
        reg_wdata_o = 16'h0000;
        reg_wr_o = 1'b0;
        reg_rd_o = 1'b0;
    end

    task automatic host_write(input logic [7:0] a, input logic [15:0] d);
        @(posedge clk_sys_i);
        reg_addr_o <= a;
        reg_wdata_o <= d & 16'hFFFE;
        reg_wr_o <= 1'b1;
        @(posedge clk_sys_i);
        reg_wr_o <= 1'b0;
        // Released lines show a changed pattern
        reg_addr_o <= ~a;
        reg_wdata_o <= ~d;
    endtask

    task automatic host_read(input logic [7:0] a, output logic [15:0] d);
        int n;
        @(posedge clk_sys_i);
        reg_addr_o <= a;
        reg_rd_o <= 1'b1;
        @(posedge clk_sys_i);
        reg_rd_o <= 1'b0;
        reg_addr_o <= ~a;
        #1;
        for (n = 0; n < 4 && reg_rvalid_i !== 1'b1; n++) @(posedge clk_sys_i) #1;
        d = (reg_rvalid_i === 1'b1) ? reg_rdata_i : 16'hXXXX;
    endtask
endmodule // reg_host_model
